// *** pkg/ccsr_map.vh ***
// Purpose: Offsets, field positions, reset values and op codes of the core special registers
// Assumes: Included by the core register block and its arithmetic helper
// Notes: Offsets are direct addresses in the special-function space
`ifndef CCSR_MAP_VH
`define CCSR_MAP_VH

// Register offsets
`define CCSR_OFS_STACK_TOP 8'h81
`define CCSR_OFS_PTR_LOW 8'h82
`define CCSR_OFS_PTR_HIGH 8'h83
`define CCSR_OFS_STATUS 8'hd0
`define CCSR_OFS_MAIN_OPND 8'he0
`define CCSR_OFS_SECOND_OPND 8'hf0

// Reset values
`define CCSR_RST_STACK_TOP 8'h07
`define CCSR_RST_PTR_LOW 8'h00
`define CCSR_RST_PTR_HIGH 8'h00
`define CCSR_RST_STATUS 8'h00
`define CCSR_RST_MAIN_OPND 8'h00
`define CCSR_RST_SECOND_OPND 8'h00

// Status word field positions
`define CCSR_BIT_CARRY 7
`define CCSR_BIT_HALF_CARRY 6
`define CCSR_BIT_USER_ZERO 5
`define CCSR_BIT_BANK_HI 4
`define CCSR_BIT_BANK_LO 3
`define CCSR_BIT_ARITH_ERR 2
`define CCSR_BIT_USER_ONE 1
`define CCSR_BIT_PARITY 0

// Arithmetic operation codes
`define CCSR_OP_NONE 3'h0
`define CCSR_OP_ADD 3'h1
`define CCSR_OP_ADDC 3'h2
`define CCSR_OP_SUBB 3'h3
`define CCSR_OP_MUL 3'h4
`define CCSR_OP_DIV 3'h5

`endif

// *** hdl/ccsr_parity.v ***
// Purpose: Odd-parity of one byte
// Assumes: Combinational, same clock domain as the caller
// Notes: One xor stage per bit, built as a chain
`timescale 1ns/1ps
module ccsr_parity #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] data,
  output wire odd
);
  wire [WIDTH:0] chain;

  // Running xor; the last tap is one when the count of ones is odd
  assign chain[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      assign chain[i+1] = chain[i] ^ data[i];
    end
  endgenerate
  assign odd = chain[WIDTH];
endmodule

// *** hdl/ccsr_arith.v ***
// Purpose: Results and flags of add, add-with-carry, subtract-with-borrow, multiply, divide
// Assumes: Combinational; the caller latches the outputs on its start strobe
// Notes: On divide by zero the operands come back unchanged
`timescale 1ns/1ps
`include "ccsr_map.vh"
module ccsr_arith (
  input wire [2:0] op,
  input wire [7:0] acc,
  input wire [7:0] opnd_b,
  input wire [7:0] src,
  input wire carry_in,
  output reg [7:0] res_acc,
  output reg [7:0] res_b,
  output reg carry,
  output reg half_carry,
  output reg arith_err
);
  wire cin = (op == `CCSR_OP_ADDC) ? carry_in : 1'b0;
  wire [8:0] sum = {1'b0, acc} + {1'b0, src} + {8'h00, cin};
  wire [4:0] nib_sum = {1'b0, acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
  wire [8:0] diff = {1'b0, acc} - {1'b0, src} - {8'h00, carry_in};
  wire [4:0] nib_sub = {1'b0, src[3:0]} + {4'h0, carry_in};
  wire [15:0] prod = acc * opnd_b;
  wire div_zero = (opnd_b == 8'h00);

  // Flags not named by an operation fall back to zero
  always @* begin
    res_acc = acc;
    res_b = opnd_b;
    carry = 1'b0;
    half_carry = 1'b0;
    arith_err = 1'b0;
    case (op)
      `CCSR_OP_ADD, `CCSR_OP_ADDC: begin
        res_acc = sum[7:0];
        carry = sum[8];
        half_carry = nib_sum[4];
        arith_err = (acc[7] == src[7]) && (sum[7] != acc[7]);
      end
      `CCSR_OP_SUBB: begin
        res_acc = diff[7:0];
        carry = diff[8];
        half_carry = ({1'b0, acc[3:0]} < nib_sub);
        arith_err = (acc[7] != src[7]) && (diff[7] != acc[7]);
      end
      `CCSR_OP_MUL: begin
        res_acc = prod[7:0];
        res_b = prod[15:8];
        arith_err = (prod[15:8] != 8'h00);
      end
      `CCSR_OP_DIV: begin
        if (!div_zero) begin
          res_acc = acc / opnd_b;
          res_b = acc % opnd_b;
        end
        arith_err = div_zero;
      end
      default: begin
        res_acc = acc;
      end
    endcase
  end
endmodule

// *** hdl/ccsr_core.v ***
// Purpose: Core special registers of an 8-bit CPU: data pointer, stack top, operands, status
// Assumes: Execution logic on clk drives the direct-access, bit, arithmetic and stack strobes
// Notes: Within one cycle a direct write beats a bit write, which beats arithmetic results
//        Spare arithmetic codes 0, 6 and 7 leave operands and flags untouched
//        The stack memory sits outside; only its addresses, write data and strobes come from here
`timescale 1ns/1ps
`include "ccsr_map.vh"
module ccsr_core (
  input wire clk,
  input wire sys_rst,
  // Direct byte access
  input wire [7:0] sfr_addr,
  input wire sfr_wr_en,
  input wire [7:0] sfr_wr_data,
  input wire sfr_rd_en,
  output reg [7:0] sfr_rd_data,
  output reg sfr_rd_hit,
  // Direct bit access
  input wire [7:0] bit_addr,
  input wire bit_wr_en,
  input wire bit_wr_val,
  input wire bit_rd_en,
  output reg bit_rd_val,
  output reg bit_rd_hit,
  // Arithmetic
  input wire alu_start,
  input wire [2:0] alu_op,
  input wire [7:0] alu_src,
  // Stack
  input wire push_en,
  input wire [7:0] push_data,
  input wire pop_en,
  output reg stack_wr_en,
  output reg [7:0] stack_wr_addr,
  output reg [7:0] stack_wr_data,
  output reg [7:0] stack_rd_addr,
  // Data pointer
  input wire ptr_inc,
  // State seen by the rest of the core
  output reg [7:0] pointer_low_byte,
  output reg [7:0] pointer_high_byte,
  output reg [7:0] stack_top_pointer,
  output reg [7:0] main_operand_register,
  output reg [7:0] second_operand_register,
  output reg [7:0] program_status_word,
  output reg [4:0] bank_base
);

  // Writable status bits live in flags; parity sits in a flop of its own
  reg carry_flag;
  reg half_carry_flag;
  reg user_flag_zero;
  reg [1:0] bank_select;
  reg arith_error_flag;
  reg user_flag_one;
  reg parity_flag;

  // Next values
  reg [7:0] next_low;
  reg [7:0] next_high;
  reg [7:0] next_sp;
  reg [7:0] next_acc;
  reg [7:0] next_b;
  reg [7:0] next_psw;
  reg [7:0] next_rd_data;
  reg next_rd_hit;
  reg next_bit_val;
  reg next_bit_hit;

  // Status word as software sees it
  wire [7:0] psw_now = {carry_flag, half_carry_flag, user_flag_zero, bank_select,
                        arith_error_flag, user_flag_one, parity_flag};

  // Sixteen-bit data pointer and its increment
  wire [15:0] data_pointer = {pointer_high_byte, pointer_low_byte};
  wire [15:0] pointer_plus = data_pointer + 16'h0001;

  // Bit access decode: upper five address bits name the byte
  wire [7:0] bit_byte = {bit_addr[7:3], 3'h0};
  wire [2:0] bit_pos = bit_addr[2:0];

  // Arithmetic results from the helper
  wire [7:0] ar_acc;
  wire [7:0] ar_b;
  wire ar_carry;
  wire ar_half;
  wire ar_err;

  // Only the five defined operations may touch results; a spare code would
  // otherwise clear carry, half carry and error through the helper's defaults
  reg op_known;
  always @* begin
    op_known = 1'b0;
    case (alu_op)
      `CCSR_OP_ADD: op_known = 1'b1;
      `CCSR_OP_ADDC: op_known = 1'b1;
      `CCSR_OP_SUBB: op_known = 1'b1;
      `CCSR_OP_MUL: op_known = 1'b1;
      `CCSR_OP_DIV: op_known = 1'b1;
      default: op_known = 1'b0;
    endcase
  end
  wire arith_go = alu_start && op_known;
  wire mul_div = (alu_op == `CCSR_OP_MUL) || (alu_op == `CCSR_OP_DIV);

  ccsr_arith u_arith (
    .op(alu_op),
    .acc(main_operand_register),
    .opnd_b(second_operand_register),
    .src(alu_src),
    .carry_in(carry_flag),
    .res_acc(ar_acc),
    .res_b(ar_b),
    .carry(ar_carry),
    .half_carry(ar_half),
    .arith_err(ar_err)
  );

  // Parity follows the operand value that will be stored next,
  // so the flop matches the operand register in every cycle
  wire next_parity;
  ccsr_parity #(
    .WIDTH(8)
  ) u_parity (
    .data(next_acc),
    .odd(next_parity)
  );

  // Returns a byte with one bit replaced
  function [7:0] ccsr_set_bit;
    input [7:0] value;
    input [2:0] pos;
    input val;
    reg [7:0] mask;
    begin
      mask = 8'h01 << pos;
      ccsr_set_bit = val ? (value | mask) : (value & ~mask);
    end
  endfunction

  // Arithmetic first, then bit writes, then byte writes
  always @* begin
    next_low = pointer_low_byte;
    next_high = pointer_high_byte;
    next_sp = stack_top_pointer;
    next_acc = main_operand_register;
    next_b = second_operand_register;
    next_psw = psw_now;
    // Pointer increment carries across both bytes
    if (ptr_inc) begin
      next_low = pointer_plus[7:0];
      next_high = pointer_plus[15:8];
    end
    // Stack top moves before the stored byte lands
    if (push_en) begin
      next_sp = stack_top_pointer + 8'h01;
    end else if (pop_en) begin
      next_sp = stack_top_pointer - 8'h01;
    end
    // Result flags; user flags and bank select are left alone
    if (arith_go) begin
      next_acc = ar_acc;
      if (mul_div) begin
        next_b = ar_b;
      end
      next_psw[`CCSR_BIT_CARRY] = ar_carry;
      next_psw[`CCSR_BIT_HALF_CARRY] = ar_half;
      next_psw[`CCSR_BIT_ARITH_ERR] = ar_err;
    end
    // Bit writes reach only the bit-addressable bytes
    if (bit_wr_en) begin
      case (bit_byte)
        `CCSR_OFS_MAIN_OPND: begin
          next_acc = ccsr_set_bit(next_acc, bit_pos, bit_wr_val);
        end
        `CCSR_OFS_SECOND_OPND: begin
          next_b = ccsr_set_bit(next_b, bit_pos, bit_wr_val);
        end
        `CCSR_OFS_STATUS: begin
          next_psw = ccsr_set_bit(next_psw, bit_pos, bit_wr_val);
        end
        default: begin
          next_psw = next_psw;
        end
      endcase
    end
    // Byte writes; unmapped offsets are dropped
    if (sfr_wr_en) begin
      case (sfr_addr)
        `CCSR_OFS_STACK_TOP: begin
          next_sp = sfr_wr_data;
        end
        `CCSR_OFS_PTR_LOW: begin
          next_low = sfr_wr_data;
        end
        `CCSR_OFS_PTR_HIGH: begin
          next_high = sfr_wr_data;
        end
        `CCSR_OFS_STATUS: begin
          // Bit 0 is carried along here but dropped at the flops
          next_psw = sfr_wr_data;
        end
        `CCSR_OFS_MAIN_OPND: begin
          next_acc = sfr_wr_data;
        end
        `CCSR_OFS_SECOND_OPND: begin
          next_b = sfr_wr_data;
        end
        default: next_psw = next_psw;
      endcase
    end
  end

  // Byte read mux; parity is shown live, unmapped reads give zero
  always @* begin
    next_rd_data = 8'h00;
    next_rd_hit = 1'b0;
    if (sfr_rd_en) begin
      next_rd_hit = 1'b1;
      case (sfr_addr)
        `CCSR_OFS_STACK_TOP: next_rd_data = stack_top_pointer;
        `CCSR_OFS_PTR_LOW: next_rd_data = pointer_low_byte;
        `CCSR_OFS_PTR_HIGH: next_rd_data = pointer_high_byte;
        `CCSR_OFS_STATUS: next_rd_data = psw_now;
        `CCSR_OFS_MAIN_OPND: next_rd_data = main_operand_register;
        `CCSR_OFS_SECOND_OPND: next_rd_data = second_operand_register;
        default: next_rd_hit = 1'b0;
      endcase
    end
  end

  // Bit read mux over the three bit-addressable bytes
  always @* begin
    next_bit_val = 1'b0;
    next_bit_hit = 1'b0;
    if (bit_rd_en) begin
      next_bit_hit = 1'b1;
      case (bit_byte)
        `CCSR_OFS_MAIN_OPND: next_bit_val = main_operand_register[bit_pos];
        `CCSR_OFS_SECOND_OPND: next_bit_val = second_operand_register[bit_pos];
        `CCSR_OFS_STATUS: next_bit_val = psw_now[bit_pos];
        default: next_bit_hit = 1'b0;
      endcase
    end
  end

  // Register state
  always @(posedge clk) begin
    if (sys_rst) begin
      pointer_low_byte <= `CCSR_RST_PTR_LOW;
      pointer_high_byte <= `CCSR_RST_PTR_HIGH;
      stack_top_pointer <= `CCSR_RST_STACK_TOP;
      main_operand_register <= `CCSR_RST_MAIN_OPND;
      second_operand_register <= `CCSR_RST_SECOND_OPND;
      carry_flag <= 1'b0;
      half_carry_flag <= 1'b0;
      user_flag_zero <= 1'b0;
      bank_select <= 2'h0;
      arith_error_flag <= 1'b0;
      user_flag_one <= 1'b0;
      parity_flag <= 1'b0;
    end else begin
      pointer_low_byte <= next_low;
      pointer_high_byte <= next_high;
      stack_top_pointer <= next_sp;
      main_operand_register <= next_acc;
      second_operand_register <= next_b;
      carry_flag <= next_psw[`CCSR_BIT_CARRY];
      half_carry_flag <= next_psw[`CCSR_BIT_HALF_CARRY];
      user_flag_zero <= next_psw[`CCSR_BIT_USER_ZERO];
      bank_select <= next_psw[`CCSR_BIT_BANK_HI:`CCSR_BIT_BANK_LO];
      arith_error_flag <= next_psw[`CCSR_BIT_ARITH_ERR];
      user_flag_one <= next_psw[`CCSR_BIT_USER_ONE];
      // Written value for bit 0 is ignored
      parity_flag <= next_parity;
    end
  end

  // Bank base from the bank select about to be stored; each code is eight bytes up
  reg [4:0] next_bank_base;
  always @* begin
    case (next_psw[`CCSR_BIT_BANK_HI:`CCSR_BIT_BANK_LO])
      2'h0: next_bank_base = 5'h00;
      2'h1: next_bank_base = 5'h08;
      2'h2: next_bank_base = 5'h10;
      2'h3: next_bank_base = 5'h18;
      default: next_bank_base = 5'h00;
    endcase
  end

  // Mirrors of the status word and bank base, kept as flops for clean outputs
  always @(posedge clk) begin
    if (sys_rst) begin
      program_status_word <= `CCSR_RST_STATUS;
      bank_base <= 5'h00;
    end else begin
      program_status_word <= {next_psw[7:1], next_parity};
      bank_base <= next_bank_base;
    end
  end

  // Read answers one cycle after the request
  always @(posedge clk) begin
    if (sys_rst) begin
      sfr_rd_data <= 8'h00;
      sfr_rd_hit <= 1'b0;
      bit_rd_val <= 1'b0;
      bit_rd_hit <= 1'b0;
    end else begin
      sfr_rd_data <= next_rd_data;
      sfr_rd_hit <= next_rd_hit;
      bit_rd_val <= next_bit_val;
      bit_rd_hit <= next_bit_hit;
    end
  end

  // Stack memory strobes; the store uses the raised address, one cycle after the push
  // Pop exposes the current top, the caller reads memory there
  always @(posedge clk) begin
    if (sys_rst) begin
      stack_wr_en <= 1'b0;
      stack_wr_addr <= 8'h00;
      stack_wr_data <= 8'h00;
      stack_rd_addr <= 8'h00;
    end else begin
      stack_wr_en <= push_en;
      if (push_en) begin
        stack_wr_addr <= stack_top_pointer + 8'h01;
        stack_wr_data <= push_data;
      end
      if (pop_en && !push_en) begin
        stack_rd_addr <= stack_top_pointer;
      end
    end
  end

endmodule

// *** test/ccsr_core_sva.sv ***
// Purpose: Port-level checks of the core special registers
// Assumes: Bound to ccsr_core; one clock, synchronous active-high reset
// Notes: Arithmetic checks skip cycles where a direct or bit write wins the register
`timescale 1ns/1ps
module ccsr_core_sva (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] sfr_addr,
  input wire sfr_wr_en,
  input wire [7:0] sfr_wr_data,
  input wire sfr_rd_en,
  input wire [7:0] sfr_rd_data,
  input wire sfr_rd_hit,
  input wire bit_wr_en,
  input wire alu_start,
  input wire [2:0] alu_op,
  input wire [7:0] alu_src,
  input wire push_en,
  input wire stack_wr_en,
  input wire [7:0] stack_wr_addr,
  input wire ptr_inc,
  input wire [7:0] pointer_low_byte,
  input wire [7:0] pointer_high_byte,
  input wire [7:0] stack_top_pointer,
  input wire [7:0] main_operand_register,
  input wire [7:0] second_operand_register,
  input wire [7:0] program_status_word,
  input wire [4:0] bank_base
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Writes outrank arithmetic, so results are only judged without them
  wire quiet = !sfr_wr_en && !bit_wr_en;
  a_rd_stack_top: assert property (
    sfr_rd_en && sfr_addr == 8'h81 |=> sfr_rd_hit && sfr_rd_data == $past(stack_top_pointer))
    else $error("stack top read wrong");
  a_parity_live: assert property (
    program_status_word[0] == ^main_operand_register)
    else $error("parity bit wrong");
  a_bank_map: assert property (
    bank_base == {program_status_word[4:3], 3'b000})
    else $error("bank base wrong");
  a_push_order: assert property (
    push_en && !sfr_wr_en |=> stack_wr_en && stack_wr_addr == $past(stack_top_pointer) + 8'h01
      && stack_top_pointer == stack_wr_addr)
    else $error("push order wrong");
  a_add_carry: assert property (
    alu_start && alu_op == 3'h1 && quiet |=> {program_status_word[7], main_operand_register}
      == $past(main_operand_register) + $past(alu_src))
    else $error("add sum or carry wrong");
  a_add_half: assert property (
    alu_start && alu_op == 3'h1 && quiet |=> program_status_word[6]
      == ((($past(main_operand_register) & 8'h0f) + ($past(alu_src) & 8'h0f)) > 8'd15))
    else $error("half carry wrong");
  a_mul_error: assert property (
    alu_start && alu_op == 3'h4 && quiet |=> {second_operand_register, main_operand_register}
      == $past(main_operand_register) * $past(second_operand_register)
      && program_status_word[2] == (second_operand_register != 8'h00) && !program_status_word[7])
    else $error("multiply result wrong");
  a_div_error: assert property (
    alu_start && alu_op == 3'h5 && quiet |=> program_status_word[2]
      == ($past(second_operand_register) == 8'h00))
    else $error("divide error flag wrong");
  a_status_write: assert property (
    sfr_wr_en && sfr_addr == 8'hd0 |=> program_status_word[7:1] == $past(sfr_wr_data) >> 1)
    else $error("status write wrong");
  a_ptr_step: assert property (
    ptr_inc && !sfr_wr_en |=> {pointer_high_byte, pointer_low_byte}
      == {$past(pointer_high_byte), $past(pointer_low_byte)} + 16'h0001)
    else $error("pointer step wrong");
  a_spare_op: assert property (
    alu_start && alu_op > 3'h5 && quiet |=> main_operand_register == $past(main_operand_register)
      && program_status_word[7:1] == $past(program_status_word[7:1]))
    else $error("spare op changed state");
  c_push: cover property (push_en ##1 stack_wr_en);
  c_mul: cover property (alu_start && alu_op == 3'h4);
  c_div_zero: cover property (alu_start && alu_op == 3'h5 && second_operand_register == 8'h00);
  c_status_write: cover property (sfr_wr_en && sfr_addr == 8'hd0);
endmodule

// *** test/test_cpu_core_special_registers.sv ***
// Purpose: Self-checking bench of the core special registers against a bench model
// Assumes: 100 MHz clk, synchronous active-high sys_rst held 10 cycles
// Notes: Each strobe is one cycle wide and followed by an idle cycle, except a bit write, which a bit read follows at once
`timescale 1ns/1ps
module test_cpu_core_special_registers;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [7:0] sfr_addr = 8'h00, sfr_wr_data = 8'h00, bit_addr = 8'h00, alu_src = 8'h00;
  reg [7:0] push_data = 8'h00;
  reg sfr_wr_en = 0, sfr_rd_en = 0, bit_wr_en = 0, bit_wr_val = 0, bit_rd_en = 0;
  reg alu_start = 0, push_en = 0, pop_en = 0, ptr_inc = 0;
  reg [2:0] alu_op = 3'h0;
  wire [7:0] rdat, swa, swd, sra, plo, phi, top, opa, opb, stat;
  wire rhit, bval, bhit, swe;
  wire [4:0] bank;
  reg [7:0] m_top = 8'h07, m_plo = 0, m_phi = 0, m_opa = 0, m_opb = 0, m_stat = 0;
  reg [7:0] tbl [0:7] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0, 8'h80, 8'hff};
  reg [31:0] r;
  integer seed = 32'hc253;
  integer num_errors = 0;
  integer checks = 0;
  integer i;
  ccsr_core u_ccsr_core (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
    .sfr_wr_en(sfr_wr_en), .sfr_wr_data(sfr_wr_data), .sfr_rd_en(sfr_rd_en),
    .sfr_rd_data(rdat), .sfr_rd_hit(rhit), .bit_addr(bit_addr), .bit_wr_en(bit_wr_en),
    .bit_wr_val(bit_wr_val), .bit_rd_en(bit_rd_en), .bit_rd_val(bval), .bit_rd_hit(bhit),
    .alu_start(alu_start), .alu_op(alu_op), .alu_src(alu_src), .push_en(push_en),
    .push_data(push_data), .pop_en(pop_en), .stack_wr_en(swe), .stack_wr_addr(swa),
    .stack_wr_data(swd), .stack_rd_addr(sra), .ptr_inc(ptr_inc), .pointer_low_byte(plo),
    .pointer_high_byte(phi), .stack_top_pointer(top), .main_operand_register(opa),
    .second_operand_register(opb), .program_status_word(stat), .bank_base(bank));
  // Free-running 100 MHz clock
  initial forever #5 clk = ~clk;
  task tick;
    @(posedge clk);
    #1;
  endtask
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Model view of a byte; parity is rebuilt from the operand, never stored
  function [7:0] mv(input [7:0] a);
    case (a)
      8'h81: mv = m_top;
      8'h82: mv = m_plo;
      8'h83: mv = m_phi;
      8'hd0: mv = {m_stat[7:1], ^m_opa};
      8'he0: mv = m_opa;
      8'hf0: mv = m_opb;
      default: mv = 8'h00;
    endcase
  endfunction
  task put(input [7:0] a, input [7:0] d);
    case (a)
      8'h81: m_top = d;
      8'h82: m_plo = d;
      8'h83: m_phi = d;
      8'hd0: m_stat = d;
      8'he0: m_opa = d;
      8'hf0: m_opb = d;
      default: ;
    endcase
  endtask
  task chk_all;
    chk(top, m_top);
    chk({phi, plo}, {m_phi, m_plo});
    chk({opa, opb}, {m_opa, m_opb});
    chk(stat, mv(8'hd0));
    chk(bank, {m_stat[4:3], 3'b000});
  endtask
  task wr(input [7:0] a, input [7:0] d);
    sfr_addr = a;
    sfr_wr_data = d;
    sfr_wr_en = 1;
    tick;
    sfr_wr_en = 0;
    put(a, d);
    tick;
    chk_all;
  endtask
  task rd(input [7:0] a);
    sfr_addr = a;
    sfr_rd_en = 1;
    tick;
    sfr_rd_en = 0;
    chk({rhit, rdat}, {mv(a) != 0 || a[7:4] == 4'h8 && a < 8'h84 && a > 8'h80
      || a == 8'hd0 || a == 8'he0 || a == 8'hf0, mv(a)});
    tick;
  endtask
  // Bit write then bit read of the same place; only three bytes answer
  task bits(input [7:0] a, input v);
    reg [7:0] t;
    reg ok;
    bit_addr = a;
    bit_wr_val = v;
    bit_wr_en = 1;
    tick;
    bit_wr_en = 0;
    ok = a[7:3] == 5'h1a || a[7:3] == 5'h1c || a[7:3] == 5'h1e;
    t = mv({a[7:3], 3'b000});
    t[a[2:0]] = v;
    if (ok) put({a[7:3], 3'b000}, t);
    bit_rd_en = 1;
    tick;
    bit_rd_en = 0;
    t = mv({a[7:3], 3'b000});
    chk(bhit, ok);
    if (ok) chk(bval, t[a[2:0]]);
    tick;
    chk_all;
  endtask
  task alu(input [2:0] op, input [7:0] src);
    integer s, c;
    alu_op = op;
    alu_src = src;
    alu_start = 1;
    tick;
    alu_start = 0;
    c = (op == 3'h1) ? 0 : m_stat[7];
    if (op == 3'h1 || op == 3'h2) begin
      s = m_opa + src + c;
      m_stat[6] = (m_opa % 16) + (src % 16) + c > 15;
      m_stat[2] = m_opa[7] == src[7] && s[7] != m_opa[7];
      m_stat[7] = s > 255;
      m_opa = s;
    end else if (op == 3'h3) begin
      s = m_opa - src - c;
      m_stat[6] = (m_opa % 16) < (src % 16) + c;
      m_stat[2] = m_opa[7] != src[7] && s[7] != m_opa[7];
      m_stat[7] = s < 0;
      m_opa = s;
    end else if (op == 3'h4) begin
      s = m_opa * m_opb;
      m_stat[7:6] = 2'b00;
      m_stat[2] = s > 255;
      m_opa = s;
      m_opb = s >> 8;
    end else if (op == 3'h5) begin
      m_stat[7:6] = 2'b00;
      m_stat[2] = m_opb == 0;
      s = m_opb ? m_opa / m_opb : m_opa;
      m_opb = m_opb ? m_opa % m_opb : m_opb;
      m_opa = s;
    end
    tick;
    chk_all;
  endtask
  // Push or pop; the written place and the new top appear together
  task stk(input p, input [7:0] d);
    push_en = p;
    pop_en = !p;
    push_data = d;
    tick;
    push_en = 0;
    pop_en = 0;
    if (p) m_top = m_top + 8'h01;
    if (p) chk({swe, swa, swd}, {1'b1, m_top, d});
    else chk(sra, m_top);
    if (!p) m_top = m_top - 8'h01;
    chk(top, m_top);
    tick;
    chk(swe, 1'b0);
  endtask
  task ptr_step;
    ptr_inc = 1;
    tick;
    ptr_inc = 0;
    {m_phi, m_plo} = {m_phi, m_plo} + 16'h0001;
    tick;
    chk_all;
  endtask
  task report_and_stop;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Whole run is well under two thousand cycles; this cuts a hang short
  initial begin
    #200000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 sys_rst = 0;
    chk_all;
    for (i = 0; i < 8; i++) rd(tbl[i]);
    stk(1, 8'haa);
    stk(0, 8'h00);
    $display("test reset and first push done");
    for (i = 0; i < 48; i++) begin
      r = $random(seed);
      wr(tbl[i % 8], r[7:0]);
      rd(tbl[(i + 3) % 8]);
    end
    for (i = 0; i < 4; i++) wr(8'hd0, {3'b000, i[1:0], 3'b001});
    $display("test byte access done");
    for (i = 0; i < 64; i++) begin
      r = $random(seed);
      bits({tbl[3 + i % 4][7:3], r[2:0]}, r[3]);
    end
    $display("test bit access done");
    wr(8'he0, 8'h7f);
    alu(3'h1, 8'h01);
    for (i = 0; i < 200; i++) begin
      r = $random(seed);
      if (r[9]) wr(8'he0, r[7:0]);
      if (r[8]) wr(8'hf0, r[16] ? 8'h00 : r[15:8]);
      alu(r[26:24], r[31:24]);
    end
    $display("test arithmetic done");
    wr(8'h81, 8'hff);
    stk(1, 8'h5c);
    stk(0, 8'h00);
    wr(8'h82, 8'hff);
    ptr_step;
    ptr_step;
    $display("test stack and pointer done");
    report_and_stop;
  end
endmodule
bind ccsr_core ccsr_core_sva u_sva (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
  .sfr_wr_en(sfr_wr_en), .sfr_wr_data(sfr_wr_data), .sfr_rd_en(sfr_rd_en),
  .sfr_rd_data(sfr_rd_data), .sfr_rd_hit(sfr_rd_hit), .bit_wr_en(bit_wr_en),
  .alu_start(alu_start), .alu_op(alu_op), .alu_src(alu_src), .push_en(push_en),
  .stack_wr_en(stack_wr_en), .stack_wr_addr(stack_wr_addr), .ptr_inc(ptr_inc),
  .pointer_low_byte(pointer_low_byte), .pointer_high_byte(pointer_high_byte),
  .stack_top_pointer(stack_top_pointer), .main_operand_register(main_operand_register),
  .second_operand_register(second_operand_register),
  .program_status_word(program_status_word), .bank_base(bank_base));
